/* core/ssr_pkg.sv */
// Shared constants for the swipe sensor frame readout, both ends.
// Assumes one system clock; the pixel clock is a synchronous strobe.
package ssr_pkg;
   localparam int NIB_W = 4;
   localparam int BYTE_W = 8;
   localparam int COLS_TRUE = 280;
   localparam int COLS_TOTAL = COLS_TRUE + 1;
   localparam int PAIRS_PER_COL = 4;
   localparam int FRAME_BYTES = COLS_TOTAL * PAIRS_PER_COL;
   localparam int PIPE_FILL = 4;
   localparam logic [8:0] COL_LAST = 9'(COLS_TOTAL - 1);
   localparam logic [8:0] COL_FIRST = 9'h000;
   localparam logic [1:0] PAIR_LAST = 2'(PAIRS_PER_COL - 1);
   localparam logic [1:0] PAIR_FIRST = 2'h0;
   localparam logic [1:0] PAIR_TEMP = 2'h2;
   localparam logic [3:0] SYNC_ODD = 4'hF;
   localparam logic [3:0] SYNC_EVEN = 4'h0;
   localparam logic [10:0] FRAME_LAST = 11'(FRAME_BYTES - 1);
   localparam logic [2:0] FILL_LAST = 3'(PIPE_FILL - 1);
   localparam logic [3:0] TEMP_ODD_DEF = 4'h5;
   localparam logic [3:0] TEMP_EVEN_DEF = 4'hA;
endpackage

/* core/ssr_link_if.sv */
// Pin-level link between the sensor readout and its host controller.
// Assumes both ends run on sys_clk; pixel clock is a level sampled on it.
`timescale 1ns/1ps
interface ssr_link_if;
   logic pix_clk;
   logic sensor_rst;
   logic out_disable;
   logic heater_enable;
   logic [3:0] odd_pixel_nibble;
   logic [3:0] even_pixel_nibble;
   logic data_oe;
   logic byte_acknowledge;
   modport sensor (input pix_clk, input sensor_rst, input out_disable, input heater_enable,
      output odd_pixel_nibble, output even_pixel_nibble, output data_oe,
      output byte_acknowledge);
   modport host (output pix_clk, output sensor_rst, output out_disable,
      output heater_enable, input odd_pixel_nibble, input even_pixel_nibble,
      input data_oe, input byte_acknowledge);
endinterface

/* core/ssr_sensor.sv */
// Contract
// [R1] Data pins released while output disable high
// [R2] Odd nibble bit 0 LSB, bit 3 MSB
// [R3] Even nibble bit 0 LSB, bit 3 MSB
// [R4] Byte acknowledge output for EPP handshake
// [R5] Select one of 281 columns per time
// [R6] Two lines per clock, two 4-bit conversions
// [R7] Both pixels delivered as one byte
// [R8] Pixel reset independent of digital reset
// [R9] Host pulses reset before read clocks
// [R10] Host gives 4 priming clocks
// [R11] Host discards first frame
// [R12] Reset once, recommended per acquisition
// [R13] 1124 clocks per frame, byte each
// [R14] Reset low while frames read
// [R15] Each column eight pixels, four pairs
// [R16] Sample clock falling, update on rising
// [R17] Odd 1,3,5,7; even 2,4,6,8
// [R18] Sync column: two 0000/1111, then temperature
// [R19] Host drives heater enable by temperature
// [R20] Counters wrap after sync column
// [R21] Reset holds counters and pipeline initial
//
// Sensor end: column/pair scan, digitised pixel pipeline, pin drivers.
// Assumes pixel array values arrive on pix_odd/pix_even for the addressed pair.
`timescale 1ns/1ps
module ssr_sensor
   import ssr_pkg::*;
(
   // System
   input wire logic sys_clk,
   input wire logic nrst,
   // Link
   ssr_link_if.sensor link,
   // Pixel array side
   input wire logic [3:0] pix_odd,
   input wire logic [3:0] pix_even,
   input wire logic [3:0] temp_odd,
   input wire logic [3:0] temp_even,
   output logic [8:0] col_sel,
   output logic [1:0] pair_sel,
   output logic pix_integ_start
);
   // Conversion depth in falling clocks. The host reads each byte as it lowers the
   // clock after the rise that loaded it, so this depth plus the pin register makes
   // the host's priming clocks land the first pixel pair on the first frame byte.
   localparam int CONV_DEPTH = PIPE_FILL - 1;

   // Edge detector and scan position
   logic clk_d_r;
   logic [8:0] col_r;
   logic [8:0] col_nxt;
   logic [1:0] pair_r;
   logic [1:0] pair_nxt;
   // Converted pairs in flight, oldest at the top index
   logic [3:0] odd_pipe_r [CONV_DEPTH];
   logic [3:0] even_pipe_r [CONV_DEPTH];
   logic [3:0] odd_nxt;
   logic [3:0] even_nxt;
   // Pin registers
   logic [3:0] odd_r;
   logic [3:0] even_r;
   logic ack_r;
   logic oe_r;
   logic integ_r;

   // Nibble for the addressed pair: array data, or the sync marker then temperature in the last column.
   // One function serves both halves so odd and even cannot disagree on the layout.
   function automatic logic [3:0] pick_nibble(
      logic sync,
      logic [1:0] pair,
      logic [3:0] array_val,
      logic [3:0] marker,
      logic [3:0] temp_val
   );
      if (!sync)
         return array_val;
      if (pair < PAIR_TEMP)
         return marker; // [R18]
      return temp_val;
   endfunction

   // Edge decode of the host pixel clock against its previous sample
   wire clk_fall = clk_d_r & ~link.pix_clk; // [R16]
   wire clk_rise = ~clk_d_r & link.pix_clk; // [R16]
   wire col_end = (pair_r == PAIR_LAST); // [R15]
   wire in_sync = (col_r == COL_LAST); // [R18]
   wire frame_end = col_end & in_sync; // [R20]
   // A falling clock that really moves the scan; clocks under sensor reset are ignored
   wire scan_step = clk_fall & ~link.sensor_rst;

   // Scan advance: pair then column, wrap to first column after sync
   assign pair_nxt = col_end ? PAIR_FIRST : 2'(pair_r + 2'h1); // [R15]
   assign col_nxt = frame_end ? COL_FIRST : (col_end ? 9'(col_r + 9'h001) : col_r); // [R5] [R20]

   // Line pair for this clock; bytes 3 and 4 of the sync column carry temperature
   assign odd_nxt = pick_nibble(in_sync, pair_r, pix_odd, SYNC_ODD, temp_odd); // [R17]
   assign even_nxt = pick_nibble(in_sync, pair_r, pix_even, SYNC_EVEN, temp_even); // [R17]

   // Sample the pixel clock each cycle; the reset value matches the idle low clock
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         clk_d_r <= 1'b0;
      else
         clk_d_r <= link.pix_clk;
   end

   // Scan counters step on the falling pixel clock
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         col_r <= COL_FIRST;
         pair_r <= PAIR_FIRST;
      end
      else if (link.sensor_rst)
      begin
         col_r <= COL_FIRST; // [R21]
         pair_r <= PAIR_FIRST; // [R21]
      end
      else if (clk_fall)
      begin
         col_r <= col_nxt; // [R5] [R20]
         pair_r <= pair_nxt; // [R15]
      end
   end

   // Conversion pipeline: a new pair enters at index 0 and moves up once per falling clock.
   // Sensor reset empties it, so priming always starts from the first pixel pair.
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         for (int i = 0; i < CONV_DEPTH; i++)
         begin
            odd_pipe_r[i] <= 4'h0;
            even_pipe_r[i] <= 4'h0;
         end
      end
      else if (link.sensor_rst)
      begin
         for (int i = 0; i < CONV_DEPTH; i++)
         begin
            odd_pipe_r[i] <= 4'h0; // [R21]
            even_pipe_r[i] <= 4'h0; // [R21]
         end
      end
      else if (clk_fall)
      begin
         odd_pipe_r[0] <= odd_nxt; // [R6]
         even_pipe_r[0] <= even_nxt; // [R6]
         for (int i = 1; i < CONV_DEPTH; i++)
         begin
            odd_pipe_r[i] <= odd_pipe_r[i - 1];
            even_pipe_r[i] <= even_pipe_r[i - 1];
         end
      end
   end

   // Output byte updates on the rising pixel clock, one byte per clock
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         odd_r <= 4'h0;
         even_r <= 4'h0;
      end
      else if (link.sensor_rst)
      begin
         odd_r <= 4'h0; // [R21]
         even_r <= 4'h0;
      end
      else if (clk_rise)
      begin
         odd_r <= odd_pipe_r[CONV_DEPTH - 1]; // [R7] [R13]
         even_r <= even_pipe_r[CONV_DEPTH - 1]; // [R7]
      end
   end

   // Acknowledge spans the low half of each pixel clock, one cycle behind its high half, usable as an EPP strobe
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         ack_r <= 1'b0;
      else if (link.sensor_rst)
         ack_r <= 1'b0;
      else if (clk_rise)
         ack_r <= 1'b1; // [R4]
      else if (clk_fall)
         ack_r <= 1'b0; // [R4]
   end

   // Registered drive enable; low disable means drive, one cycle behind the pin
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         oe_r <= 1'b0;
      else
         oe_r <= ~link.out_disable; // [R1]
   end

   // Integration restart pulse at each frame wrap, never from sensor reset itself
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         integ_r <= 1'b0;
      else
         integ_r <= scan_step & frame_end; // [R8]
   end

   // Pins and array address straight from their registers
   assign link.odd_pixel_nibble = odd_r; // [R2]
   assign link.even_pixel_nibble = even_r; // [R3]
   assign link.data_oe = oe_r; // [R1]
   assign link.byte_acknowledge = ack_r;
   assign col_sel = col_r;
   assign pair_sel = pair_r;
   assign pix_integ_start = integ_r;
endmodule

/* core/ssr_host.sv */
// Host end: start sequence, priming, first-frame discard, frame streaming.
// Assumes the sensor end samples the pins on sys_clk.
`timescale 1ns/1ps
module ssr_host
   import ssr_pkg::*;
(
   // System
   input wire logic sys_clk,
   input wire logic nrst,
   // Link
   ssr_link_if.host link,
   // User side
   input wire logic start,
   input wire logic stop,
   input wire logic heat_req,
   output logic [7:0] byte_data,
   output logic byte_valid,
   output logic frame_first,
   output logic busy
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RST = 3'b001,
      ST_FILL = 3'b011,
      ST_SKIP = 3'b010,
      ST_RUN = 3'b110
   } ssr_state_t;
   ssr_state_t st_r, st_nxt;
   logic clk_r, rst_r, heat_r, valid_r, first_r, busy_r, rel_r;
   logic [10:0] cnt_r;
   logic [7:0] data_r;

   // Each pixel clock is one high cycle then one low; the falling half ends a clock
   wire clk_done = clk_r;
   wire fill_done = clk_done & (cnt_r[2:0] == FILL_LAST); // [R10]
   wire frm_done = clk_done & (cnt_r == FRAME_LAST); // [R13]

   // Sequencer
   always_comb
   begin
      st_nxt = st_r;
      unique case (st_r)
         ST_IDLE: if (start) st_nxt = ST_RST;
         ST_RST: st_nxt = ST_FILL; // [R9] [R12]
         ST_FILL: if (fill_done) st_nxt = ST_SKIP;
         ST_SKIP: if (frm_done) st_nxt = ST_RUN; // [R11]
         ST_RUN: if (stop & frm_done) st_nxt = ST_IDLE;
         default: st_nxt = ST_IDLE;
      endcase
   end

   // State, pixel clock and cycle count
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st_r <= ST_IDLE;
         clk_r <= 1'b0;
         rst_r <= 1'b0;
         cnt_r <= 11'h000;
      end
      else
      begin
         st_r <= st_nxt;
         rst_r <= (st_nxt == ST_RST); // [R9]
         clk_r <= (st_nxt != ST_IDLE && st_nxt != ST_RST) ? ~clk_r : 1'b0; // [R14]
         if (st_nxt != st_r || frm_done)
            cnt_r <= 11'h000;
         else if (clk_done)
            cnt_r <= 11'(cnt_r + 11'h001);
      end
   end

   // Capture byte on falling pixel edge, deliver only after discarded frame
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         data_r <= 8'h00;
         valid_r <= 1'b0;
         first_r <= 1'b0;
         heat_r <= 1'b0;
         busy_r <= 1'b0;
         rel_r <= 1'b1;
      end
      else
      begin
         valid_r <= clk_done & (st_r == ST_RUN); // [R11]
         first_r <= clk_done & (st_r == ST_RUN) & (cnt_r == 11'h000);
         if (clk_done)
            data_r <= {link.even_pixel_nibble, link.odd_pixel_nibble};
         heat_r <= heat_req; // [R19]
         busy_r <= (st_nxt != ST_IDLE);
         rel_r <= (st_nxt == ST_IDLE); // [R1]
      end
   end

   assign link.pix_clk = clk_r;
   assign link.sensor_rst = rst_r;
   // Sensor data pins released whenever no acquisition runs
   assign link.out_disable = rel_r;
   assign link.heater_enable = heat_r;
   assign byte_data = data_r;
   assign byte_valid = valid_r;
   assign frame_first = first_r;
   assign busy = busy_r;
endmodule

/* dv/ssr_link_sva.sv */
// Link checker for the swipe sensor readout, both ends on one interface.
// Assumes every link signal is sampled on sys_clk by both ends.
`timescale 1ns/1ps
module ssr_link_sva (
   // System
   input wire logic sys_clk,
   input wire logic nrst,
   // Link
   input wire logic pix_clk,
   input wire logic sensor_rst,
   input wire logic out_disable,
   input wire logic [3:0] odd_pixel_nibble,
   input wire logic [3:0] even_pixel_nibble,
   input wire logic data_oe,
   input wire logic byte_acknowledge
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   logic [2:0] lag_r;
   // Clock rises not yet answered; a wrap below zero shows a spurious acknowledge
   always_ff @(posedge sys_clk or negedge nrst)
      if (!nrst)
         lag_r <= 3'h0;
      else if (sensor_rst)
         lag_r <= 3'h0;
      else
         lag_r <= lag_r + 3'($rose(pix_clk)) - 3'($rose(byte_acknowledge));
   // One acknowledge per byte, high for the low half of the clock
   sequence ack_pulse;
      byte_acknowledge ##1 !byte_acknowledge;
   endsequence
   release_ok_a: assert property (data_oe == !$past(out_disable))
      else $error("data drive not following output disable");
   ack_pulse_a: assert property ($rose(byte_acknowledge) |-> ack_pulse)
      else $error("acknowledge not a one cycle pulse");
   ack_per_clock_a: assert property (lag_r <= 3'h1)
      else $error("acknowledge count off from clock count");
   fall_hold_a: assert property ($fell(byte_acknowledge) && !$past(sensor_rst)
      |-> $stable({odd_pixel_nibble, even_pixel_nibble}))
      else $error("data changed on falling clock");
   rst_clear_a: assert property (sensor_rst |=>
      odd_pixel_nibble == 4'h0 && even_pixel_nibble == 4'h0 && !byte_acknowledge)
      else $error("sensor reset did not clear outputs");
   rst_pulse_a: assert property ($rose(sensor_rst) |=> !sensor_rst)
      else $error("reset pulse too long");
   rst_quiet_a: assert property ($rose(pix_clk) |-> !sensor_rst)
      else $error("clock sent during reset");
   ack_driven_a: assert property (byte_acknowledge |-> data_oe)
      else $error("byte acknowledged while data not driven");
endmodule

/* dv/tb.sv */
// Bench for host and sensor ends joined on one link interface.
// Assumes the pixel array answers col_sel and pair_sel at once.
`timescale 1ns/1ps
module tb;
   import ssr_pkg::*;
   logic sys_clk = 0, nrst = 0, start = 0, stop = 0, heat_req = 0;
   logic [3:0] temp_odd = 4'h6, temp_even = 4'h9;
   logic [3:0] pix_odd, pix_even;
   logic [8:0] col_sel;
   logic [1:0] pair_sel;
   logic pix_integ_start, byte_valid, frame_first, busy;
   logic [7:0] byte_data;
   int fail_count = 0, cmp_count = 0, cycles = 0, rises = 0, integs = 0;
   ssr_link_if link ();
   ssr_sensor ssr_sensor_inst (.sys_clk(sys_clk), .nrst(nrst), .link(link.sensor),
      .pix_odd(pix_odd), .pix_even(pix_even), .temp_odd(temp_odd), .temp_even(temp_even),
      .col_sel(col_sel), .pair_sel(pair_sel), .pix_integ_start(pix_integ_start));
   ssr_host ssr_host_inst (.sys_clk(sys_clk), .nrst(nrst), .link(link.host), .start(start),
      .stop(stop), .heat_req(heat_req), .byte_data(byte_data), .byte_valid(byte_valid),
      .frame_first(frame_first), .busy(busy));
   ssr_link_sva ssr_link_sva_inst (.sys_clk(sys_clk), .nrst(nrst), .pix_clk(link.pix_clk),
      .sensor_rst(link.sensor_rst), .out_disable(link.out_disable),
      .odd_pixel_nibble(link.odd_pixel_nibble), .even_pixel_nibble(link.even_pixel_nibble),
      .data_oe(link.data_oe), .byte_acknowledge(link.byte_acknowledge));
   // Pixel values coded from their address so a slip of one pair or one column shows
   assign pix_odd = col_sel[3:0] ^ {pair_sel, 2'h1};
   assign pix_even = col_sel[7:4] + {2'h0, pair_sel};
   initial
      forever #5 sys_clk = ~sys_clk;
   // Clock rises since the last sensor reset
   always @(posedge link.pix_clk)
      rises++;
   always @(posedge link.sensor_rst)
   begin
      rises = 0;
      integs = 0;
   end
   // Integration restarts since the last sensor reset
   always @(posedge sys_clk)
      if (pix_integ_start === 1'b1)
         integs++;
   // Cut a hang short; the run needs about 13500 cycles
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         fail_count++;
         results();
      end
   end
   function automatic logic [7:0] exp_byte(int k);
      logic [8:0] c;
      logic [1:0] p;
      c = 9'(k / 4);
      p = 2'(k % 4);
      if (c == COL_LAST)
         return (p < PAIR_TEMP) ? {SYNC_EVEN, SYNC_ODD} : {temp_even, temp_odd};
      return {c[7:4] + {2'h0, p}, c[3:0] ^ {p, 2'h1}};
   endfunction
   task automatic check(logic [7:0] seen, logic [7:0] want);
      cmp_count++;
      if (seen !== want)
      begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic step(int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // Take one whole frame from the user side; first says a start preceded it
   task automatic read_frame(bit first);
      for (int k = 0; k < FRAME_BYTES; k++)
      begin
         do @(negedge sys_clk); while (byte_valid !== 1'b1);
         if (first && k == 0)
         begin
            check(8'(rises >= PIPE_FILL + FRAME_BYTES), 8'h01);
            check(8'(integs), 8'h01);
            check(8'(link.data_oe), 8'h01);
         end
         check(8'(frame_first), 8'(k == 0));
         check(byte_data, exp_byte(k));
      end
   endtask
   task automatic results();
      $display("mismatches %0d comparisons %0d", fail_count, cmp_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      step(6);
      nrst = 1;
      heat_req = 1;
      step(3);
      check(8'(link.heater_enable), 8'h01);
      heat_req = 0;
      start = 1;
      step(3);
      check(8'(link.heater_enable), 8'h00);
      read_frame(1);
      read_frame(0);
      step(1);
      start = 0;
      stop = 1;
      while (busy !== 1'b0)
         @(negedge sys_clk);
      step(1);
      check(8'(link.data_oe), 8'h00);
      stop = 0;
      start = 1;
      read_frame(1);
      results();
   end
endmodule
